// [logic/rcw_params.svh]
`ifndef RCW_PARAMS_SVH
`define RCW_PARAMS_SVH

// register indexes (byte address is four times the index)
`define RCW_IDX_SERVICE 16'hffff
`define RCW_IDX_CONFIG 16'h0010
`define RCW_IDX_STATUS 16'h0011

// configuration register fields
`define RCW_CFG_DISABLE_BIT 0
`define RCW_CFG_RATE_BIT 1
`define RCW_CFG_RESET_PIN_FUNCTION_ENABLE_BIT 2
`define RCW_CFG_RESET 3'h0

// status register fields
`define RCW_ST_CAUSE_BIT 0
`define RCW_ST_ENABLED_BIT 1
`define RCW_ST_PIN_BIT 2
`define RCW_ST_COP_LSB 8

// reset vector low byte seen on a service read (arbitrary value)
`define RCW_RESET_VEC_LO 8'h00

// axi responses
`define RCW_RESP_OKAY 2'h0
`define RCW_RESP_SLVERR 2'h2

// counter layout
`define RCW_PRE_WIDTH 12
`define RCW_COP_WIDTH 6
`define RCW_PRE_KEEP_MASK 12'h00f
`define RCW_COP_LONG_LAST 6'h3f
`define RCW_COP_SHORT_LAST 6'h01

// timing, in oscillator cycles (one core_clk cycle each)
`define RCW_RST_PIN_CYCLES 32
`define RCW_POR_CYCLES 4096

`endif

// [logic/rcw_pkg.sv]
package rcw_pkg;

  // reset pin driver states
  typedef enum logic {
    RCW_PIN_IDLE,
    RCW_PIN_DRIVE
  } rcw_pin_state_type;

  // software configuration bits
  typedef struct packed {
    logic rst_pin_en;
    logic rate_short;
    logic disable_wd;
  } rcw_cfg_type;

endpackage

// [logic/rcw_cnt_if.sv]
`timescale 1ns/1ps
`default_nettype none

// control and status between the bus side and the counter chain
interface rcw_cnt_if;
  logic run;
  logic enable;
  logic clr_pre;
  logic clr_cop;
  logic service;
  logic rate_short;
  logic overflow;
  logic [11:0] pre;
  logic [5:0] runaway_watchdog;

  modport ctrl (
    output run,
    output enable,
    output clr_pre,
    output clr_cop,
    output service,
    output rate_short,
    input overflow,
    input pre,
    input runaway_watchdog
  );

  modport cnt (
    input run,
    input enable,
    input clr_pre,
    input clr_cop,
    input service,
    input rate_short,
    output overflow,
    output pre,
    output runaway_watchdog
  );
endinterface

`default_nettype wire

// [logic/rcw_counter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rcw_params.svh"

// prescaler feeding the six-stage watchdog counter
module rcw_counter
  import rcw_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  rcw_cnt_if.cnt cnt
);

  logic [11:0] pre_r;
  logic [11:0] pre_nxt;
  logic [5:0] cop_r;
  logic [5:0] cop_nxt;
  logic ovf_r;
  logic ovf_nxt;
  logic wrap;       // prescaler carry into the watchdog stage
  logic [5:0] last; // count at which the next carry overflows

  // next count values
  always_comb
  begin
    pre_nxt = pre_r;
    cop_nxt = cop_r;
    ovf_nxt = 1'b0;
    wrap = &pre_r;
    last = cnt.rate_short ? `RCW_COP_SHORT_LAST : `RCW_COP_LONG_LAST;
    if (cnt.clr_pre)
    begin
      pre_nxt = '0;
    end
    else if (cnt.service)
    begin
      pre_nxt = pre_r & `RCW_PRE_KEEP_MASK;
    end
    else if (cnt.run)
    begin
      pre_nxt = pre_r + 12'h001;
    end
    if (cnt.clr_cop || !cnt.enable || cnt.service)
    begin
      cop_nxt = '0;
    end
    else if (cnt.run && wrap && !cnt.clr_pre)
    begin
      if (cop_r == last)
      begin
        cop_nxt = '0;
        ovf_nxt = 1'b1;
      end
      else
      begin
        cop_nxt = cop_r + 6'h01;
      end
    end
  end

  // count registers
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      pre_r <= '0;
      cop_r <= '0;
      ovf_r <= 1'b0;
    end
    else
    begin
      pre_r <= pre_nxt;
      cop_r <= cop_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  assign cnt.pre = pre_r;
  assign cnt.runaway_watchdog = cop_r;
  assign cnt.overflow = ovf_r;

endmodule // rcw_counter

`default_nettype wire

// [logic/rcw_top.sv]
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rcw_params.svh"

module rcw_top
  import rcw_pkg::*;
#(
  parameter int ADDR_W = 18
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic stop_mode,
  input wire logic wait_mode,
  input wire logic internal_rst,
  input wire logic monitor_mode,
  input wire logic monitor_test_voltage,
  input wire logic break_active,
  input wire logic break_disables_watchdog,
  output logic wd_reset,
  output logic rst_pin_n_out,
  output logic rst_pin_oe
);

  rcw_cnt_if cnt_if ();

  // bus state
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic aw_full_r, aw_full_nxt;
  logic w_full_r, w_full_nxt;
  logic [15:0] aw_idx_r, aw_idx_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic wstrb0_r, wstrb0_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic do_wr;          // both halves of a write are held
  logic [15:0] ar_idx;  // read word index

  // configuration and status state
  rcw_cfg_type cfg_r, cfg_nxt;
  logic cfg_lock_r, cfg_lock_nxt;
  logic cause_r, cause_nxt;
  logic service;

  // reset pin and power-on state
  rcw_pin_state_type pin_r, pin_nxt;
  logic [5:0] pin_cnt_r, pin_cnt_nxt;
  logic [12:0] por_cnt_r, por_cnt_nxt;
  logic por_clr_r, por_clr_nxt;
  logic wd_reset_r, wd_reset_nxt;

  // test voltage pin synchroniser
  logic vtst_meta_r;
  logic vtst_sync_r;
  logic enabled;

  // two flops before anything reads the pin
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      vtst_meta_r <= 1'b0;
      vtst_sync_r <= 1'b0;
    end
    else
    begin
      vtst_meta_r <= monitor_test_voltage;
      vtst_sync_r <= vtst_meta_r;
    end
  end

  // watchdog enable and counter control
  always_comb
  begin
    enabled = !cfg_r.disable_wd;
    if (monitor_mode && vtst_sync_r)
    begin
      enabled = 1'b0;
    end
    if (monitor_mode && break_active && break_disables_watchdog)
    begin
      enabled = 1'b0;
    end
  end

  assign cnt_if.enable = enabled;
  // stop gates oscillator; wait keeps running
  assign cnt_if.run = !stop_mode;
  // stop, reset and por clear prescaler
  assign cnt_if.clr_pre = stop_mode || internal_rst || por_clr_r;
  assign cnt_if.clr_cop = internal_rst;
  assign cnt_if.service = service;
  assign cnt_if.rate_short = cfg_r.rate_short;

  // counters run on core_clk, the oscillator
  rcw_counter u_counter (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .cnt(cnt_if)
  );

  // axi-lite write and read channels
  always_comb
  begin
    awready_nxt = awready_r;
    wready_nxt = wready_r;
    aw_full_nxt = aw_full_r;
    w_full_nxt = w_full_r;
    aw_idx_nxt = aw_idx_r;
    wdata_nxt = wdata_r;
    wstrb0_nxt = wstrb0_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    ar_idx = s_axi_araddr[17:2];
    // write waits for an earlier response to drain
    do_wr = aw_full_r && w_full_r && !bvalid_r;
    if (s_axi_awvalid && awready_r)
    begin
      aw_full_nxt = 1'b1;
      aw_idx_nxt = s_axi_awaddr[17:2];
    end
    if (s_axi_wvalid && wready_r)
    begin
      w_full_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb0_nxt = s_axi_wstrb[0];
    end
    if (do_wr)
    begin
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = `RCW_RESP_SLVERR;
      if (aw_idx_r == `RCW_IDX_SERVICE || aw_idx_r == `RCW_IDX_CONFIG
          || aw_idx_r == `RCW_IDX_STATUS)
      begin
        bresp_nxt = `RCW_RESP_OKAY;
      end
    end
    else if (bvalid_r && s_axi_bready)
    begin
      bvalid_nxt = 1'b0;
    end
    awready_nxt = !aw_full_nxt;
    wready_nxt = !w_full_nxt;
    // read answered the cycle after it is taken
    if (s_axi_arvalid && arready_r)
    begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt = `RCW_RESP_OKAY;
      rdata_nxt = '0;
      unique case (ar_idx)
        `RCW_IDX_SERVICE: rdata_nxt[7:0] = `RCW_RESET_VEC_LO;
        `RCW_IDX_CONFIG: rdata_nxt[2:0] = cfg_r;
        `RCW_IDX_STATUS:
        begin
          rdata_nxt[`RCW_ST_CAUSE_BIT] = cause_r;
          rdata_nxt[`RCW_ST_ENABLED_BIT] = enabled;
          rdata_nxt[`RCW_ST_PIN_BIT] = (pin_r == RCW_PIN_DRIVE);
          rdata_nxt[`RCW_ST_COP_LSB +: 6] = cnt_if.runaway_watchdog;
        end
        default: rresp_nxt = `RCW_RESP_SLVERR;
      endcase
    end
    else if (rvalid_r && s_axi_rready)
    begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  // bus registers
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_idx_r <= '0;
      wdata_r <= '0;
      wstrb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `RCW_RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `RCW_RESP_OKAY;
    end
    else
    begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      aw_idx_r <= aw_idx_nxt;
      wdata_r <= wdata_nxt;
      wstrb0_r <= wstrb0_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // configuration, service and cause flag
  always_comb
  begin
    cfg_nxt = cfg_r;
    cfg_lock_nxt = cfg_lock_r;
    cause_nxt = cause_r;
    service = do_wr && (aw_idx_r == `RCW_IDX_SERVICE);
    if (do_wr && wstrb0_r && aw_idx_r == `RCW_IDX_CONFIG)
    begin
      // pin enable stays writable; period and disable only once
      cfg_nxt.rst_pin_en = wdata_r[`RCW_CFG_RESET_PIN_FUNCTION_ENABLE_BIT];
      if (!cfg_lock_r)
      begin
        cfg_nxt.disable_wd = wdata_r[`RCW_CFG_DISABLE_BIT];
        cfg_nxt.rate_short = wdata_r[`RCW_CFG_RATE_BIT];
        cfg_lock_nxt = 1'b1;
      end
    end
    // write one clears the cause flag
    if (do_wr && wstrb0_r && aw_idx_r == `RCW_IDX_STATUS
        && wdata_r[`RCW_ST_CAUSE_BIT])
    begin
      cause_nxt = 1'b0;
    end
    // overflow sets cause, wins over clear
    if (cnt_if.overflow && enabled)
    begin
      cause_nxt = 1'b1;
    end
  end

  // configuration registers
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cfg_r <= `RCW_CFG_RESET;
      cfg_lock_r <= 1'b0;
      cause_r <= 1'b0;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      cfg_lock_r <= cfg_lock_nxt;
      cause_r <= cause_nxt;
    end
  end

  // reset pulse, pin driver and power-on prescaler clear
  always_comb
  begin
    pin_nxt = pin_r;
    pin_cnt_nxt = pin_cnt_r;
    por_cnt_nxt = por_cnt_r;
    por_clr_nxt = 1'b0;
    // overflow gives a reset, never an interrupt
    wd_reset_nxt = cnt_if.overflow && enabled;
    // one clear after the power-on delay
    if (por_cnt_r != 13'(`RCW_POR_CYCLES))
    begin
      por_cnt_nxt = por_cnt_r + 13'h0001;
      por_clr_nxt = (por_cnt_nxt == 13'(`RCW_POR_CYCLES));
    end
    unique case (pin_r)
      RCW_PIN_IDLE:
      begin
        if (wd_reset_nxt && cfg_r.rst_pin_en)
        begin
          pin_nxt = RCW_PIN_DRIVE;
          pin_cnt_nxt = 6'(`RCW_RST_PIN_CYCLES - 1);
        end
      end
      RCW_PIN_DRIVE:
      begin
        if (pin_cnt_r == 6'h00)
        begin
          pin_nxt = RCW_PIN_IDLE;
        end
        else
        begin
          pin_cnt_nxt = pin_cnt_r - 6'h01;
        end
      end
    endcase
  end

  // pin and power-on registers
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      pin_r <= RCW_PIN_IDLE;
      pin_cnt_r <= '0;
      por_cnt_r <= '0;
      por_clr_r <= 1'b0;
      wd_reset_r <= 1'b0;
    end
    else
    begin
      pin_r <= pin_nxt;
      pin_cnt_r <= pin_cnt_nxt;
      por_cnt_r <= por_cnt_nxt;
      por_clr_r <= por_clr_nxt;
      wd_reset_r <= wd_reset_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign wd_reset = wd_reset_r;
  // open drain: only ever drives low
  assign rst_pin_n_out = 1'b0;
  assign rst_pin_oe = (pin_r == RCW_PIN_DRIVE);

endmodule // rcw_top

`default_nettype wire

// [bench/rcw_top_assertions.sv]
`timescale 1ns/1ps
`default_nettype none

// watches the top ports only: bus timing and watchdog outcome
module rcw_top_assertions (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic stop_mode,
  input wire logic internal_rst,
  input wire logic monitor_mode,
  input wire logic monitor_test_voltage,
  input wire logic break_active,
  input wire logic break_disables_watchdog,
  input wire logic wd_reset,
  input wire logic rst_pin_n_out,
  input wire logic rst_pin_oe
);
  logic [5:0] oe_cnt_r; // cycles the pin has been pulled so far
  logic [5:0] oe_cnt_nxt;

  // count pin-low cycles; a counter avoids a 32-deep repetition
  always_comb
  begin
    oe_cnt_nxt = rst_pin_oe ? oe_cnt_r + 6'h01 : 6'h00;
  end

  always_ff @(posedge core_clk)
  begin
    oe_cnt_r <= sys_rst ? 6'h00 : oe_cnt_nxt;
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // a few cycles of margin cover the disable path latency
  sequence brk_off;
    (monitor_mode && break_active && break_disables_watchdog)[*3];
  endsequence
  sequence vtst_off;
    (monitor_mode && monitor_test_voltage)[*5];
  endsequence

  chk_pin_length: assert property ($fell(rst_pin_oe) |-> oe_cnt_r == 6'h20)
    else $error("reset pin pulse length wrong");
  chk_pin_bound: assert property (rst_pin_oe |-> oe_cnt_r < 6'h20)
    else $error("reset pin held too long");
  chk_pin_cause: assert property ($rose(rst_pin_oe) |-> wd_reset && !rst_pin_n_out)
    else $error("reset pin pulled without watchdog reset");
  chk_reset_single: assert property (wd_reset |=> (!wd_reset)[*8])
    else $error("watchdog reset not a single pulse");
  chk_brk_quiet: assert property (brk_off |-> !wd_reset)
    else $error("watchdog reset during break disable");
  chk_vtst_quiet: assert property (vtst_off |-> !wd_reset)
    else $error("watchdog reset in monitor mode");
  chk_stop_quiet: assert property (stop_mode[*3] |-> !wd_reset)
    else $error("watchdog reset in stop mode");
  chk_int_clear: assert property (internal_rst |-> ##2 (!wd_reset)[*8])
    else $error("watchdog reset right after internal reset");
  chk_wr_answer: assert property (wr_taken |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
    else $error("write response timing wrong");
  chk_rd_answer: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response timing wrong");
endmodule // rcw_top_assertions

bind rcw_top rcw_top_assertions u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .stop_mode(stop_mode), .internal_rst(internal_rst),
  .monitor_mode(monitor_mode), .monitor_test_voltage(monitor_test_voltage),
  .break_active(break_active), .break_disables_watchdog(break_disables_watchdog),
  .wd_reset(wd_reset), .rst_pin_n_out(rst_pin_n_out), .rst_pin_oe(rst_pin_oe)
);

`default_nettype wire

// [bench/runaway_code_watchdog_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rcw_params.svh"

module runaway_code_watchdog_bench
  import rcw_pkg::*;
;
  logic core_clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic stop_mode, wait_mode, internal_rst, monitor_mode, monitor_test_voltage;
  logic break_active, break_disables_watchdog, wd_reset, rst_pin_n_out, rst_pin_oe;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d; // rd_d: last read word
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp; // rsp: last response code
  int errors, samples_checked, n_first, n_pulse, n_oe;

  rcw_top #(.ADDR_W(18)) DUT (
    .core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .stop_mode(stop_mode), .wait_mode(wait_mode),
    .internal_rst(internal_rst), .monitor_mode(monitor_mode),
    .monitor_test_voltage(monitor_test_voltage), .break_active(break_active),
    .break_disables_watchdog(break_disables_watchdog), .wd_reset(wd_reset),
    .rst_pin_n_out(rst_pin_n_out), .rst_pin_oe(rst_pin_oe)
  );

  // 10 mhz oscillator
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // verdict and end of run, also reached on a hung bus
  task automatic finish_test();
    if (errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // counts measured by the bench against an allowed band
  task automatic chk_range(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    samples_checked++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask

  // shortest period after a service, in oscillator cycles
  function automatic int period(input bit short_sel);
    return short_sel ? 8176 : 262128;
  endfunction

  function automatic logic [31:0] exp_status(input bit cause, input bit en);
    return (32'(cause) << `RCW_ST_CAUSE_BIT) | (32'(en) << `RCW_ST_ENABLED_BIT);
  endfunction

  // one bus transfer; valid signals are dropped at the edge they are taken
  task automatic axi(input bit wr, input logic [15:0] idx, input logic [31:0] d);
    int n;
    bit done;
    n = 0;
    done = 1'b0;
    if (wr)
    begin
      s_axi_awaddr <= {idx, 2'h0};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
    end
    else
    begin
      s_axi_araddr <= {idx, 2'h0};
      s_axi_arvalid <= 1'b1;
    end
    while (!done && n < 200)
    begin
      @(posedge core_clk);
      n++;
      // only a raised valid is dropped, so a following call never meets a second assignment
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      done = wr ? s_axi_bvalid : s_axi_rvalid;
      rsp = wr ? s_axi_bresp : s_axi_rresp;
      rd_d = s_axi_rdata;
    end
    if (!done)
    begin
      errors++;
      finish_test();
    end
  endtask

  task automatic rd_cop();
    axi(1'b0, `RCW_IDX_STATUS, 32'h0);
    rd_d = (rd_d >> `RCW_ST_COP_LSB) & 32'h3f;
  endtask

  // let time pass, noting watchdog pulses and pin-low cycles
  task automatic run(input int cycles);
    n_first = 0;
    n_pulse = 0;
    n_oe = 0;
    for (int i = 1; i <= cycles; i++)
    begin
      @(posedge core_clk);
      if (wd_reset === 1'b1 && n_first == 0)
        n_first = i;
      n_pulse += int'(wd_reset === 1'b1);
      n_oe += int'(rst_pin_oe === 1'b1);
    end
  endtask

  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
  endtask

  // main sequence; ready inputs stay high so no answer is ever stalled
  initial
  begin
    {sys_rst, s_axi_bready, s_axi_rready, s_axi_wstrb} = 7'h7f;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, stop_mode, wait_mode} = 5'h0;
    {internal_rst, monitor_mode, monitor_test_voltage, break_active} = 4'h0;
    {break_disables_watchdog, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 69'h0;
    errors = 0;
    samples_checked = 0;
    void'($urandom(32'h3ae913d6));
    do_reset();
    axi(1'b0, `RCW_IDX_CONFIG, 32'h0);
    chk_word(rd_d, 32'h0);
    axi(1'b0, `RCW_IDX_STATUS, 32'h0);
    chk_word(rd_d, exp_status(1'b0, 1'b1));
    axi(1'b0, `RCW_IDX_SERVICE, 32'h0);
    chk_word(rd_d & 32'hff, {24'h0, `RCW_RESET_VEC_LO});
    axi(1'b0, 16'h0020, 32'h0);
    chk_word({30'h0, rsp}, {30'h0, `RCW_RESP_SLVERR});
    axi(1'b1, 16'h0020, $urandom);
    chk_word({30'h0, rsp}, {30'h0, `RCW_RESP_SLVERR});
    wait_mode <= 1'($urandom);
    // long period: no reset where the short one would already fire
    run(13000);
    chk_range(n_pulse, 0, 0);
    rd_cop();
    chk_range(rd_d, 1, 3);
    axi(1'b1, `RCW_IDX_SERVICE, $urandom);
    rd_cop();
    chk_word(rd_d, 32'h0);
    run(9000);
    internal_rst <= 1'b1;
    @(posedge core_clk);
    internal_rst <= 1'b0;
    rd_cop();
    chk_word(rd_d, 32'h0);
    // short period with the pin function on
    axi(1'b1, `RCW_IDX_CONFIG, 32'h6);
    chk_word({30'h0, rsp}, {30'h0, `RCW_RESP_OKAY});
    axi(1'b1, `RCW_IDX_SERVICE, $urandom);
    run(8300);
    // never early; kept low prescaler stages and the output flop add a little
    chk_range(n_first, period(1'b1), period(1'b1) + 24);
    chk_range(n_pulse, 1, 1);
    chk_range(n_oe, `RCW_RST_PIN_CYCLES, `RCW_RST_PIN_CYCLES);
    axi(1'b0, `RCW_IDX_STATUS, 32'h0);
    chk_word(rd_d & 32'h7, exp_status(1'b1, 1'b1));
    axi(1'b1, `RCW_IDX_STATUS, 32'h1);
    axi(1'b0, `RCW_IDX_STATUS, 32'h0);
    chk_word(rd_d & 32'h7, exp_status(1'b0, 1'b1));
    // stop, test voltage, break disable, and break without disable
    for (int k = 0; k < 4; k++)
    begin
      axi(1'b1, `RCW_IDX_SERVICE, $urandom);
      stop_mode <= (k == 0);
      monitor_mode <= (k >= 1);
      monitor_test_voltage <= (k == 1);
      break_active <= (k >= 2);
      break_disables_watchdog <= (k == 2);
      run(6000);
      rd_cop();
      chk_word(rd_d, 32'(k == 3));
      run(2500 + $urandom_range(199));
      chk_range(n_pulse, 32'(k == 3), 32'(k == 3));
    end
    {stop_mode, monitor_mode, monitor_test_voltage, break_active} <= 4'h0;
    // pin function off: reset still happens, pin untouched
    do_reset();
    // let the power-on prescaler clear pass first; it can swallow a carry
    run(4100);
    axi(1'b1, `RCW_IDX_CONFIG, 32'h2);
    axi(1'b1, `RCW_IDX_SERVICE, $urandom);
    run(8300);
    chk_range(n_first, period(1'b1), period(1'b1) + 24);
    chk_range(n_pulse, 1, 1);
    chk_range(n_oe, 0, 0);
    // disable bit set: the watchdog stage stays at zero, nothing fires
    do_reset();
    axi(1'b1, `RCW_IDX_CONFIG, 32'h3);
    run(9000);
    chk_range(n_pulse, 0, 0);
    axi(1'b0, `RCW_IDX_STATUS, 32'h0);
    chk_word(rd_d & 32'h3f03, 32'h0);
    finish_test();
  end
endmodule // runaway_code_watchdog_bench

`default_nettype wire
